// ===== hw/nsr_pkg.sv
// types shared by the status bank and its neighbours
`default_nettype none
package nsr_pkg;

	typedef struct packed {
		logic crc;
		logic par;
		logic soft_frm;
		logic hard_frm;
		logic wake_timeout;
		logic amp_delta;
		logic phase_delta;
		logic cap_delta;
	} nsr_err_evt_t;

	typedef struct packed {
		logic [6:0] count;
		logic       underflow;
		logic       overflow;
		logic       clear;
		logic       last_valid;
		logic       last_incomplete;
		logic [2:0] last_bits;
		logic       last_no_parity;
	} nsr_fifo_t;

	typedef struct packed {
		logic       valid;
		logic       in_range;
		logic [3:0] byte_idx;
		logic [2:0] bit_idx;
		logic       parity;
	} nsr_coll_t;

	typedef enum logic [1:0] {
		NSR_COL_ARMED = 2'h0,
		NSR_COL_HELD  = 2'h1
	} nsr_col_state_t;

endpackage

`default_nettype wire

// ===== hw/nsr_regs.svh
// register offsets, field positions, reset values for the status bank
`ifndef NSR_REGS_SVH
`define NSR_REGS_SVH

`define NSR_ADDR_W        6
`define NSR_OFF_ERR_MASK  6'h16
`define NSR_OFF_MAIN_IRQ  6'h17
`define NSR_OFF_ERR_FLAGS 6'h19
`define NSR_OFF_FILL      6'h1a
`define NSR_OFF_COND      6'h1b
`define NSR_OFF_COLL      6'h1c
`define NSR_OFF_TX_HIGH   6'h1d
`define NSR_OFF_TX_LOW    6'h1e

`define NSR_RESET_VAL     8'h00

`define NSR_ERR_CRC       7
`define NSR_ERR_PAR       6
`define NSR_ERR_SOFT      5
`define NSR_ERR_HARD      4
`define NSR_ERR_WAKE      3
`define NSR_ERR_AMP       2
`define NSR_ERR_PHASE     1
`define NSR_ERR_CAP       0

`define NSR_COND_UNF      6
`define NSR_COND_OVR      5
`define NSR_COND_NCP      4
`define NSR_COND_NP       0

`define NSR_FIFO_MAX      7'h60
`define NSR_TX_MAX        13'h1fff

`endif

// ===== hw/nsr_status_bank.sv
// error, fifo, collision and transmit-count status register bank
//
// Function
// - bits 7..5 report crc, parity, soft framing
// - bit 4 reports framing error corrupting data
// - bit 3 wake timeout, only if every-timeout
// - bits 2..0 amplitude, phase, capacitance delta
// - power-up and set-default clear whole group
// - reading main interrupt clears error flags
// - fill count bits 6..0, 0 to 96
// - bit 6 underflow, bit 5 overflow
// - incomplete last byte flag plus bit count
// - missing last parity, also a framing error
// - empty fifo zeroes count, incomplete flag and bit count
// - collision byte index and bit position
// - only collisions inside anticollision length update
// - parity-bit collision flagged, first collision only
// - transmit count bits 12..5, host respects maximum
// - companion register: count bits 4..0, split bits
// - main bit 0 pending until flags read
// - mask bit per flag suppresses interrupt request
`timescale 1ns/1ps
`include "nsr_regs.svh"
`default_nettype none

module nsr_status_bank
	import nsr_pkg::*;
(
	input  wire logic                   sys_clk,        // 100 MHz clock
	input  wire logic                   rstn,           // async reset
	input  wire logic                   set_default,    // set-default pulse
	input  wire logic [`NSR_ADDR_W-1:0] reg_addr,       // register offset
	input  wire logic                   reg_rd,         // read strobe
	input  wire logic                   reg_wr,         // write strobe
	input  wire logic [7:0]             reg_wdata,      // write data
	output logic      [7:0]             reg_rdata,      // read data
	output logic                        reg_rvalid,     // read data valid
	input  wire nsr_err_evt_t           err_evt,        // error events
	input  wire logic                   wake_irq_every, // every-timeout option
	input  wire nsr_fifo_t              fifo_in,        // fifo state
	input  wire nsr_coll_t              coll_in,        // collision report
	input  wire logic                   rx_start,       // new reception
	output logic                        err_pending,    // main irq bit 0
	output logic                        err_irq,        // unmasked flag
	output logic      [12:0]            tx_byte_count,  // bytes to send
	output logic      [2:0]             split_byte_bits // split byte bits
);

	// ****************************************
	// access decode
	// ****************************************
	logic rd_main;
	logic rd_err;
	logic wr_mask;
	logic wr_txh;
	logic wr_txl;
	assign rd_main = reg_rd && (reg_addr == `NSR_OFF_MAIN_IRQ);
	assign rd_err  = reg_rd && (reg_addr == `NSR_OFF_ERR_FLAGS);
	assign wr_mask = reg_wr && (reg_addr == `NSR_OFF_ERR_MASK);
	assign wr_txh  = reg_wr && (reg_addr == `NSR_OFF_TX_HIGH);
	assign wr_txl  = reg_wr && (reg_addr == `NSR_OFF_TX_LOW);

	// ****************************************
	// state
	// ****************************************
	logic [7:0]     flags_q;
	logic [7:0]     mask_q;
	logic           pend_q;
	logic [6:0]     count_q;
	logic           unf_q;
	logic           ovr_q;
	logic           ncp_q;
	logic [2:0]     lb_q;
	logic           np_q;
	logic [7:0]     cpos_q;
	nsr_col_state_t col_q;
	logic [7:0]     txh_q;
	logic [7:0]     txl_q;
	logic [7:0]     flag_set;
	logic           coll_take;
	logic           fifo_empty;
	assign fifo_empty = (fifo_in.count == 7'h00);
	assign coll_take  = coll_in.valid && (col_q == NSR_COL_ARMED);

	// ****************************************
	// error and wake-up flags
	// ****************************************
	always_comb begin
		flag_set                = 8'h00;
		flag_set[`NSR_ERR_CRC]  = err_evt.crc;
		flag_set[`NSR_ERR_PAR]  = err_evt.par
			|| (coll_take && coll_in.in_range && coll_in.parity);
		flag_set[`NSR_ERR_SOFT] = err_evt.soft_frm;
		flag_set[`NSR_ERR_HARD] = err_evt.hard_frm
			|| (fifo_in.last_valid && fifo_in.last_no_parity);
		flag_set[`NSR_ERR_WAKE] = err_evt.wake_timeout && wake_irq_every;
		flag_set[`NSR_ERR_AMP]   = err_evt.amp_delta;
		flag_set[`NSR_ERR_PHASE] = err_evt.phase_delta;
		flag_set[`NSR_ERR_CAP]   = err_evt.cap_delta;
	end
	// set wins over the read-clear
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			flags_q <= `NSR_RESET_VAL;
		end else if (set_default) begin
			flags_q <= `NSR_RESET_VAL;
		end else begin
			flags_q <= (rd_main ? 8'h00 : flags_q) | flag_set;
		end
	end
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			mask_q <= `NSR_RESET_VAL;
		end else if (set_default) begin
			mask_q <= `NSR_RESET_VAL;
		end else if (wr_mask) begin
			mask_q <= reg_wdata;
		end
	end
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pend_q <= 1'b0;
		end else if (set_default) begin
			pend_q <= 1'b0;
		end else if (|(flag_set & ~mask_q)) begin
			pend_q <= 1'b1;
		end else if (rd_err) begin
			pend_q <= 1'b0;
		end
	end
	assign err_pending = pend_q;
	assign err_irq     = |(flags_q & ~mask_q);

	// ****************************************
	// fifo status
	// ****************************************
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			count_q <= 7'h00;
		end else if (set_default) begin
			count_q <= 7'h00;
		end else begin
			count_q <= fifo_in.count;
		end
	end
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			unf_q <= 1'b0;
			ovr_q <= 1'b0;
		end else if (set_default) begin
			unf_q <= 1'b0;
			ovr_q <= 1'b0;
		end else begin
			unf_q <= fifo_in.underflow || (unf_q && !fifo_in.clear);
			ovr_q <= fifo_in.overflow || (ovr_q && !fifo_in.clear);
		end
	end
	// empty fifo overrides the last-byte report
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ncp_q <= 1'b0;
			lb_q  <= 3'h0;
			np_q  <= 1'b0;
		end else if (set_default) begin
			ncp_q <= 1'b0;
			lb_q  <= 3'h0;
			np_q  <= 1'b0;
		end else if (fifo_empty) begin
			ncp_q <= 1'b0;
			lb_q  <= 3'h0;
			np_q  <= np_q && !fifo_in.clear;
		end else if (fifo_in.last_valid) begin
			ncp_q <= fifo_in.last_incomplete;
			lb_q  <= fifo_in.last_incomplete ? fifo_in.last_bits : 3'h0;
			np_q  <= fifo_in.last_no_parity;
		end
	end

	// ****************************************
	// collision display
	// ****************************************
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			col_q <= NSR_COL_ARMED;
		end else if (set_default || rx_start) begin
			col_q <= NSR_COL_ARMED;
		end else begin
			case (col_q)
				NSR_COL_ARMED: begin
					if (coll_in.valid) begin
						col_q <= NSR_COL_HELD;
					end
				end
				NSR_COL_HELD: begin
					col_q <= NSR_COL_HELD;
				end
				default: begin
					col_q <= NSR_COL_ARMED;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cpos_q <= `NSR_RESET_VAL;
		end else if (set_default) begin
			cpos_q <= `NSR_RESET_VAL;
		end else if (coll_take && coll_in.in_range) begin
			cpos_q <= {coll_in.byte_idx, coll_in.bit_idx, coll_in.parity};
		end
	end

	// ****************************************
	// transmit count
	// ****************************************
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			txh_q <= `NSR_RESET_VAL;
			txl_q <= `NSR_RESET_VAL;
		end else if (set_default) begin
			txh_q <= `NSR_RESET_VAL;
			txl_q <= `NSR_RESET_VAL;
		end else begin
			if (wr_txh) begin
				txh_q <= reg_wdata;
			end
			if (wr_txl) begin
				txl_q <= reg_wdata;
			end
		end
	end
	assign tx_byte_count   = {txh_q, txl_q[7:3]};
	assign split_byte_bits = txl_q[2:0];

	// ****************************************
	// read port
	// ****************************************
	function automatic logic [7:0] rd_mux(input logic [`NSR_ADDR_W-1:0] a);
		case (a)
			`NSR_OFF_ERR_MASK:  rd_mux = mask_q;
			`NSR_OFF_MAIN_IRQ:  rd_mux = {7'h00, pend_q};
			`NSR_OFF_ERR_FLAGS: rd_mux = flags_q;
			`NSR_OFF_FILL:      rd_mux = {1'b0, count_q};
			`NSR_OFF_COND:      rd_mux = {1'b0, unf_q, ovr_q, ncp_q, lb_q, np_q};
			`NSR_OFF_COLL:      rd_mux = cpos_q;
			`NSR_OFF_TX_HIGH:   rd_mux = txh_q;
			`NSR_OFF_TX_LOW:    rd_mux = txl_q;
			default:            rd_mux = 8'h00;
		endcase
	endfunction
	// writes to read-only offsets have no decode at all
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata  <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= rd_mux(reg_addr);
			end
		end
	end

	// ****************************************
	// checks
	// ****************************************
	property p_crc_sets;
		@(posedge sys_clk) disable iff (!rstn)
		err_evt.crc && !set_default |=> flags_q[`NSR_ERR_CRC];
	endproperty
	a_crc_sets: assert property (p_crc_sets) else $error("crc flag not set");
	property p_np_frames;
		@(posedge sys_clk) disable iff (!rstn)
		fifo_in.last_valid && fifo_in.last_no_parity && !set_default
			|=> flags_q[`NSR_ERR_HARD];
	endproperty
	a_np_frames: assert property (p_np_frames) else $error("np not framing");
	property p_wake_gated;
		@(posedge sys_clk) disable iff (!rstn)
		err_evt.wake_timeout && !wake_irq_every && !flags_q[`NSR_ERR_WAKE]
			|=> !flags_q[`NSR_ERR_WAKE];
	endproperty
	a_wake_gated: assert property (p_wake_gated) else $error("wake not gated");
	property p_default_clr;
		@(posedge sys_clk) disable iff (!rstn)
		set_default |=> flags_q == 8'h00 && cpos_q == 8'h00
			&& tx_byte_count == 13'h0000 && count_q == 7'h00;
	endproperty
	a_default_clr: assert property (p_default_clr) else $error("default not clear");
	property p_main_clr;
		@(posedge sys_clk) disable iff (!rstn)
		rd_main && flag_set == 8'h00 |=> flags_q == 8'h00;
	endproperty
	a_main_clr: assert property (p_main_clr) else $error("flags kept after read");
	property p_empty_zero;
		@(posedge sys_clk) disable iff (!rstn)
		fifo_empty && !set_default |=> count_q == 7'h00 && !ncp_q && lb_q == 3'h0;
	endproperty
	a_empty_zero: assert property (p_empty_zero) else $error("empty not zero");
	property p_coll_hold;
		@(posedge sys_clk) disable iff (!rstn)
		col_q == NSR_COL_HELD && !rx_start && !set_default [*2] |=> $stable(cpos_q);
	endproperty
	a_coll_hold: assert property (p_coll_hold) else $error("display moved");
	property p_ro_write;
		@(posedge sys_clk) disable iff (!rstn)
		reg_wr && reg_addr == `NSR_OFF_ERR_FLAGS && flag_set == 8'h00
			&& !rd_main && !set_default |=> $stable(flags_q);
	endproperty
	a_ro_write: assert property (p_ro_write) else $error("ro write took");
	property p_tx_high;
		@(posedge sys_clk) disable iff (!rstn)
		wr_txh && !set_default |=> tx_byte_count[12:5] == $past(reg_wdata);
	endproperty
	a_tx_high: assert property (p_tx_high) else $error("tx count lost");
	property p_pend_clr;
		@(posedge sys_clk) disable iff (!rstn)
		rd_err && (flag_set & ~mask_q) == 8'h00 |=> !err_pending;
	endproperty
	a_pend_clr: assert property (p_pend_clr) else $error("pending stuck");
	property p_fill_read;
		@(posedge sys_clk) disable iff (!rstn)
		reg_rd && reg_addr == `NSR_OFF_FILL
			|=> reg_rvalid && !reg_rdata[7] && reg_rdata[6:0] == $past(count_q);
	endproperty
	a_fill_read: assert property (p_fill_read) else $error("fill read wrong");

endmodule // nsr_status_bank

`default_nettype wire

// ===== verification/nsr_host_model.sv
// host model driving the status bank register port
`timescale 1ns/1ps
`default_nettype none

module nsr_host_model (
	input  wire logic       sys_clk,            // bank clock
	output logic      [5:0] reg_addr,           // register offset
	output logic            reg_rd,             // read strobe
	output logic            reg_wr,             // write strobe
	output logic      [7:0] reg_wdata,          // write data
	input  wire logic [7:0] reg_rdata,          // read data
	input  wire logic       reg_rvalid          // read data valid
);
	// ********
	// access tasks
	// ********
	initial begin
		reg_addr = 6'h00;
		reg_rd = 1'b0;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
	end

	// counts above the maximum cannot be expressed here
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge sys_clk);
		reg_wr = 1'b0;
		reg_wdata = ~d;
	endtask

	task automatic rd(input logic [5:0] a, output logic [7:0] d);
		int n;
		@(negedge sys_clk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge sys_clk);
		reg_rd = 1'b0;
		n = 0;
		while (reg_rvalid !== 1'b1 && n < 4) begin
			@(negedge sys_clk);
			n++;
		end
		d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
	endtask

	// both status registers before any data, both values returned
	task automatic rd_fifo(output logic [7:0] fill, output logic [7:0] cond);
		rd(6'h1a, fill);
		rd(6'h1b, cond);
	endtask
endmodule // nsr_host_model

`default_nettype wire

// ===== verification/tb_top.sv
// self-checking bench for the status register bank
`timescale 1ns/1ps
`include "nsr_regs.svh"
`default_nettype none

module tb_top;
	import nsr_pkg::*;
	logic         sys_clk = 1'b0;
	logic         rstn = 1'b0;
	logic         set_default = 1'b0;
	logic [5:0]   reg_addr;
	logic         reg_rd;
	logic         reg_wr;
	logic [7:0]   reg_wdata;
	logic [7:0]   reg_rdata;
	logic         reg_rvalid;
	logic         wake_irq_every = 1'b0;
	logic         rx_start = 1'b0;
	logic         err_pending;
	logic         err_irq;
	logic [12:0]  tx_byte_count;
	logic [2:0]   split_byte_bits;
	logic [7:0]   d;
	logic [7:0]   d2;
	nsr_err_evt_t err_evt = '0;
	nsr_fifo_t    fifo_in = '0;
	nsr_coll_t    coll_in = '0;
	int           error_cnt = 0;
	int           n_checks = 0;
	int           cyc = 0;

	nsr_status_bank i_nsr_status_bank (.sys_clk, .rstn, .set_default, .reg_addr,
		.reg_rd, .reg_wr, .reg_wdata, .reg_rdata, .reg_rvalid, .err_evt,
		.wake_irq_every, .fifo_in, .coll_in, .rx_start, .err_pending, .err_irq,
		.tx_byte_count, .split_byte_bits);
	nsr_host_model i_nsr_host_model (.sys_clk, .reg_addr,
		.reg_rd, .reg_wr, .reg_wdata, .reg_rdata, .reg_rvalid);

	always #5 sys_clk = ~sys_clk;

	// ********
	// helpers
	// ********
	task automatic report_and_stop;
		if (error_cnt == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			report_and_stop();
		end
	end

	task automatic chk(input logic [12:0] got, input logic [12:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic rc(input logic [5:0] a, input logic [7:0] e);
		i_nsr_host_model.rd(a, d);
		chk({5'h00, d}, {5'h00, e});
	endtask

	task automatic ev(input logic [7:0] e);
		@(negedge sys_clk);
		err_evt = nsr_err_evt_t'(e);
		@(negedge sys_clk);
		err_evt = '0;
	endtask

	task automatic ff(input nsr_fifo_t f);
		@(negedge sys_clk);
		fifo_in = f;
		@(negedge sys_clk);
		fifo_in.underflow = 1'b0;
		fifo_in.overflow = 1'b0;
		fifo_in.clear = 1'b0;
		fifo_in.last_valid = 1'b0;
	endtask

	task automatic cl(input logic rs, input nsr_coll_t c);
		@(negedge sys_clk);
		rx_start = rs;
		@(negedge sys_clk);
		rx_start = 1'b0;
		coll_in = c;
		@(negedge sys_clk);
		coll_in = '0;
	endtask

	// ********
	// sequence
	// ********
	initial begin
		repeat (2) @(negedge sys_clk);
		rstn = 1'b1;
		for (int a = 'h16; a <= 'h1e; a++) rc(a[5:0], 8'h00);
		rc(6'h3f, 8'h00);
		ev(8'h08);
		rc(`NSR_OFF_ERR_FLAGS, 8'h00);
		wake_irq_every = 1'b1;
		for (int i = 0; i < 8; i++) begin
			ev(8'h01 << i);
			rc(`NSR_OFF_ERR_FLAGS, 8'hff >> (7 - i));
		end
		chk({11'h000, err_pending, err_irq}, 13'h0001);
		ev(8'h01);
		chk({11'h000, err_pending, err_irq}, 13'h0003);
		for (int a = 'h19; a <= 'h1c; a++) begin
			i_nsr_host_model.wr(a[5:0], 8'h5a);
			rc(a[5:0], (a == 'h19) ? 8'hff : 8'h00);
		end
		ev(8'h01);
		rc(`NSR_OFF_MAIN_IRQ, 8'h01);
		chk({11'h000, err_pending, err_irq}, 13'h0002);
		rc(`NSR_OFF_ERR_FLAGS, 8'h00);
		chk({11'h000, err_pending, err_irq}, 13'h0000);
		i_nsr_host_model.wr(`NSR_OFF_ERR_MASK, 8'h80);
		ev(8'h80);
		chk({11'h000, err_pending, err_irq}, 13'h0000);
		rc(`NSR_OFF_ERR_FLAGS, 8'h80);
		ff({7'h60, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 3'h5, 1'b1});
		i_nsr_host_model.rd_fifo(d, d2);
		chk({5'h00, d}, 13'h0060);
		chk({5'h00, d2}, 13'h007b);
		rc(`NSR_OFF_ERR_FLAGS, 8'h90);
		ff({7'h00, 9'h000});
		i_nsr_host_model.rd_fifo(d, d2);
		chk({5'h00, d}, 13'h0000);
		chk({5'h00, d2}, 13'h0061);
		ff({7'h00, 1'b0, 1'b0, 1'b1, 6'h00});
		rc(`NSR_OFF_COND, 8'h00);
		rc(`NSR_OFF_MAIN_IRQ, 8'h00);
		cl(1'b1, {1'b1, 1'b1, 4'h3, 3'h5, 1'b1});
		rc(`NSR_OFF_COLL, 8'h3b);
		rc(`NSR_OFF_ERR_FLAGS, 8'h40);
		cl(1'b0, {1'b1, 1'b1, 4'h7, 3'h1, 1'b1});
		rc(`NSR_OFF_COLL, 8'h3b);
		cl(1'b1, {1'b1, 1'b0, 4'h9, 3'h2, 1'b0});
		rc(`NSR_OFF_COLL, 8'h3b);
		cl(1'b1, {1'b1, 1'b1, 4'h2, 3'h1, 1'b0});
		rc(`NSR_OFF_COLL, 8'h22);
		i_nsr_host_model.wr(`NSR_OFF_TX_HIGH, 8'hff);
		i_nsr_host_model.wr(`NSR_OFF_TX_LOW, 8'hfd);
		chk(tx_byte_count, 13'h1fff);
		chk({10'h000, split_byte_bits}, 13'h0005);
		rc(`NSR_OFF_TX_HIGH, 8'hff);
		ev(8'h01);
		@(negedge sys_clk);
		set_default = 1'b1;
		@(negedge sys_clk);
		set_default = 1'b0;
		chk({err_pending, tx_byte_count[11:0]}, 13'h0000);
		for (int a = 'h16; a <= 'h1e; a++) rc(a[5:0], 8'h00);
		report_and_stop();
	end
endmodule // tb_top

`default_nettype wire
